/* core/lirs_handler.sv */
`timescale 1ns/10ps
`include "lirs_params.svh"

// How it works
// R01 - Config read-back: type 0x5e37, unit index in range.
// R02 - Config area is 40 bytes, overwritten live.
// R03 - Config confirmation has status zero and data.
// R04 - Control read-back: type 0x5e38, length 16.
// R05 - Control fields overwritten with active settings.
// R06 - Control confirmation has status zero and data.
// R07 - Switch reset: type 0x7e00, id zero, length zero.
// R08 - Switch reset confirmed only after reset completes.
// R09 - Control bytes 0,2,4 live; others zero.
// R10 - Bad unit index or length gives nonzero status.
module lirs_handler
  import lirs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Request header from the host.
  input  wire logic        req_valid_i,
  input  wire logic [15:0] req_type_i,
  input  wire logic [7:0]  req_id_i,
  input  wire logic [15:0] req_len_i,
  input  wire logic        req_rsp_i,
  output logic             req_ready_o,
  // Live configuration lookup for the selected unit.
  output logic [7:0]       unit_o,
  output logic [5:0]       area_idx_o,
  input  wire logic [7:0]  cfg_byte_i,
  // Active control settings of the selected unit.
  input  wire logic [7:0]  ctl_ais_i,
  input  wire logic [7:0]  ctl_loop_i,
  input  wire logic [7:0]  ctl_prbs_i,
  // Cross-connect switch reset handshake.
  output logic             sw_reset_o,
  input  wire logic        sw_done_i,
  // Parameter area bytes of the confirmation.
  output logic             cfm_byte_valid_o,
  output logic [7:0]       cfm_byte_o,
  output logic [5:0]       cfm_byte_off_o,
  // Confirmation header.
  output logic             cfm_valid_o,
  output logic [15:0]      cfm_type_o,
  output logic [7:0]       cfm_id_o,
  output logic [15:0]      cfm_len_o,
  output logic [7:0]       cfm_status_o
);

  // Sequencer state and the request it is serving.
  lirs_state_t state_reg;
  lirs_state_t state_next;
  lirs_kind_t  kind_reg;
  // Latched request fields; all but rsp_reg are shown on the confirmation header.
  logic [15:0] type_reg;
  logic [7:0]  unit_reg;
  logic [15:0] len_reg;
  logic        rsp_reg;
  logic [7:0]  status_reg;
  // Index of the area byte being fetched.
  logic [5:0]  idx_reg;
  // Registered outputs.
  logic        ready_reg;
  logic        sw_reset_reg;
  logic        byte_valid_reg;
  logic [7:0]  byte_reg;
  logic [5:0]  byte_off_reg;
  logic        cfm_valid_reg;

  // Request decode, done on the raw header so the check costs no cycle.
  wire         take      = req_valid_i & ready_reg;
  wire         is_cfg    = (req_type_i == `LIRS_TYPE_CFG_RB); // R01
  wire         is_ctl    = (req_type_i == `LIRS_TYPE_CTL_RB); // R04
  wire         is_rst    = (req_type_i == `LIRS_TYPE_SW_RST); // R07
  // The reset request has no unit, so its id must be zero.
  wire         id_ok     = is_rst ? (req_id_i == `LIRS_SW_RST_ID)
                                  : (req_id_i < `LIRS_NUM_UNITS); // R10
  wire [15:0]  len_want  = is_cfg ? `LIRS_LEN_CFG :
                           is_ctl ? `LIRS_LEN_CTL : `LIRS_LEN_RST;
  wire         len_ok    = (req_len_i == len_want); // R10
  wire         type_ok   = is_cfg | is_ctl | is_rst;
  // Type is judged first, then index, then length.
  wire [7:0]   chk_status = !type_ok ? `LIRS_ST_BAD_TYPE :
                            !id_ok   ? `LIRS_ST_BAD_ID   :
                            !len_ok  ? `LIRS_ST_BAD_LEN  : `LIRS_ST_OK;
  wire         req_good  = (chk_status == `LIRS_ST_OK);
  wire lirs_kind_t kind_in = is_cfg ? LIRS_K_CFG :
                             is_ctl ? LIRS_K_CTL :
                             is_rst ? LIRS_K_RST : LIRS_K_NONE;

  // Control area: only three bytes carry settings, the rest are zero.
  wire [7:0]   ctl_byte = (idx_reg == `LIRS_OFF_AIS)  ? ctl_ais_i  :
                          (idx_reg == `LIRS_OFF_LOOP) ? ctl_loop_i :
                          (idx_reg == `LIRS_OFF_PRBS) ? ctl_prbs_i :
                          `LIRS_BYTE_ZERO; // R09
  // The host's zeroed area is never read; the live value replaces it.
  wire [7:0]   live_byte = (kind_reg == LIRS_K_CFG) ? cfg_byte_i
                                                    : ctl_byte; // R02 R05
  wire [5:0]   last_idx  = 6'(len_reg - 16'h0001);
  wire         at_last   = (idx_reg == last_idx);
  wire         streaming = (state_reg == LIRS_S_STREAM);

  // Next-state selection. A read-back with no confirmation asked has
  // nowhere to deliver its data, so it is dropped without effect.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      LIRS_S_IDLE:
      begin
        if (take)
        begin
          if (!req_good)
            state_next = req_rsp_i ? LIRS_S_RESP : LIRS_S_IDLE; // R10
          else if (is_rst)
            state_next = LIRS_S_SWRST; // R07
          else
            state_next = req_rsp_i ? LIRS_S_STREAM : LIRS_S_IDLE; // R03
        end
      end
      LIRS_S_STREAM:
      begin
        if (at_last)
          state_next = LIRS_S_RESP; // R03 R06
      end
      LIRS_S_SWRST:
      begin
        // Confirmation waits for the switch to report completion.
        if (sw_done_i)
          state_next = rsp_reg ? LIRS_S_RESP : LIRS_S_IDLE; // R08
      end
      LIRS_S_RESP:
        state_next = LIRS_S_IDLE;
      default:
        state_next = LIRS_S_IDLE;
    endcase
  end

  // Sequencer state and handshake outputs.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg     <= LIRS_S_IDLE;
      ready_reg     <= 1'b0;
      cfm_valid_reg <= 1'b0;
      sw_reset_reg  <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      ready_reg     <= (state_next == LIRS_S_IDLE);
      cfm_valid_reg <= (state_reg == LIRS_S_RESP);
      // Held as a level from acceptance until the switch is done.
      sw_reset_reg  <= (state_next == LIRS_S_SWRST); // R07
    end
  end

  // Request fields are captured once, when the request is taken.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      kind_reg   <= LIRS_K_NONE;
      type_reg   <= 16'h0000;
      unit_reg   <= 8'h00;
      len_reg    <= 16'h0000;
      rsp_reg    <= 1'b0;
      status_reg <= `LIRS_ST_OK;
    end
    else if (take)
    begin
      kind_reg   <= kind_in;
      type_reg   <= req_type_i;
      unit_reg   <= req_id_i;
      len_reg    <= req_len_i;
      rsp_reg    <= req_rsp_i;
      status_reg <= chk_status; // R10
    end
  end

  // Area byte fetch: index walks one byte a cycle, data follows a cycle
  // later because the lookup answers combinationally from unit and index.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      idx_reg        <= 6'h00;
      byte_valid_reg <= 1'b0;
      byte_reg       <= `LIRS_BYTE_ZERO;
      byte_off_reg   <= 6'h00;
    end
    else
    begin
      idx_reg        <= streaming ? 6'(idx_reg + 6'h01) : 6'h00;
      byte_valid_reg <= streaming;
      byte_reg       <= streaming ? live_byte : `LIRS_BYTE_ZERO; // R02 R05
      byte_off_reg   <= idx_reg;
    end
  end

  // Outputs straight from flip-flops.
  assign req_ready_o      = ready_reg;
  assign unit_o           = unit_reg;
  assign area_idx_o       = idx_reg;
  assign sw_reset_o       = sw_reset_reg;
  assign cfm_byte_valid_o = byte_valid_reg;
  assign cfm_byte_o       = byte_reg;
  assign cfm_byte_off_o   = byte_off_reg;
  assign cfm_valid_o      = cfm_valid_reg;
  assign cfm_type_o       = type_reg;
  assign cfm_id_o         = unit_reg;
  assign cfm_len_o        = len_reg;
  assign cfm_status_o     = status_reg;

  // Checks on the sequencing, all in the one clock domain.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wire good_cfg = take & req_good & is_cfg & req_rsp_i;
  wire good_ctl = take & req_good & is_ctl & req_rsp_i;

  a_cfg_id_take: assert property (take & is_cfg & !id_ok & req_rsp_i // R01
    |-> ##2 cfm_valid_o && cfm_status_o == `LIRS_ST_BAD_ID)
    else $error("config read-back with bad unit not refused");
  a_cfg_bytes: assert property (good_cfg |-> ##2 cfm_byte_valid_o[*8]) // R02
    else $error("config area bytes not streamed back to back");
  a_cfg_confirm: assert property (good_cfg // R03
    |-> ##42 cfm_valid_o && cfm_status_o == `LIRS_ST_OK)
    else $error("config confirmation missing or late");
  a_ctl_confirm: assert property (good_ctl // R04 R06
    |-> ##18 cfm_valid_o && cfm_len_o == `LIRS_LEN_CTL)
    else $error("control confirmation missing or late");
  a_ctl_live: assert property (cfm_byte_valid_o // R05
    && kind_reg == LIRS_K_CTL && cfm_byte_off_o == `LIRS_OFF_LOOP
    |-> cfm_byte_o == $past(ctl_loop_i))
    else $error("loopback mode byte not live");
  a_ctl_reserved: assert property (cfm_byte_valid_o // R09
    && kind_reg == LIRS_K_CTL && cfm_byte_off_o != `LIRS_OFF_AIS
    && cfm_byte_off_o != `LIRS_OFF_LOOP && cfm_byte_off_o != `LIRS_OFF_PRBS
    |-> cfm_byte_o == `LIRS_BYTE_ZERO)
    else $error("reserved control byte not zero");
  a_rst_hold: assert property (sw_reset_o && !sw_done_i |=> sw_reset_o) // R07
    else $error("switch reset dropped before completion");
  a_rst_confirm: assert property (cfm_valid_o && kind_reg == LIRS_K_RST // R08
    && cfm_status_o == `LIRS_ST_OK |-> $past(sw_done_i, 2))
    else $error("switch reset confirmed before done");
  a_len_check: assert property (take & type_ok & id_ok & !len_ok // R10
    & req_rsp_i |-> ##2 cfm_valid_o && cfm_status_o == `LIRS_ST_BAD_LEN)
    else $error("wrong length not refused");

  c_cfg_done: cover property (good_cfg ##42 cfm_valid_o);
  c_ctl_done: cover property (good_ctl ##18 cfm_valid_o);
  c_rst_done: cover property (sw_reset_o ##1 !sw_reset_o ##1 cfm_valid_o);
  c_refused: cover property (cfm_valid_o && cfm_status_o != `LIRS_ST_OK);

endmodule // lirs_handler

/* core/lirs_params.svh */
`ifndef LIRS_PARAMS_SVH
`define LIRS_PARAMS_SVH

// Request type codes carried in the message header.
`define LIRS_TYPE_CFG_RB   16'h5e37
`define LIRS_TYPE_CTL_RB   16'h5e38
`define LIRS_TYPE_SW_RST   16'h7e00

// Expected parameter area lengths in bytes for each request type.
`define LIRS_LEN_CFG       16'h0028
`define LIRS_LEN_CTL       16'h0010
`define LIRS_LEN_RST       16'h0000

// Unit index that a switch reset must carry, as it names no line unit.
`define LIRS_SW_RST_ID     8'h00

// Number of fitted line units; indices run from zero to one less.
`define LIRS_NUM_UNITS     8'h04

// Byte offsets of the live fields in the control read-back area.
`define LIRS_OFF_AIS       6'h00
`define LIRS_OFF_LOOP      6'h02
`define LIRS_OFF_PRBS      6'h04

// Confirmation status codes; zero means success.
`define LIRS_ST_OK         8'h00
`define LIRS_ST_BAD_ID     8'h01
`define LIRS_ST_BAD_LEN    8'h02
`define LIRS_ST_BAD_TYPE   8'h03

// Value that reserved bytes of a read-back area carry.
`define LIRS_BYTE_ZERO     8'h00

`endif

/* core/lirs_pkg.sv */
package lirs_pkg;

  // Which request the handler is serving.
  typedef enum logic [1:0] {
    LIRS_K_NONE,
    LIRS_K_CFG,
    LIRS_K_CTL,
    LIRS_K_RST
  } lirs_kind_t;

  // Sequencer states of the command handler.
  typedef enum logic [1:0] {
    LIRS_S_IDLE,
    LIRS_S_STREAM,
    LIRS_S_SWRST,
    LIRS_S_RESP
  } lirs_state_t;

endpackage

/* sim/lirs_unit_model.sv */
`timescale 1ns/10ps
// Line units and cross-connect switch that stand beside the handler.
module lirs_unit_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Lookup driven by the handler.
  input  wire logic [7:0] unit_i,
  input  wire logic [5:0] area_idx_i,
  output logic      [7:0] cfg_byte_o,
  output logic      [7:0] ais_o,
  output logic      [7:0] loop_o,
  output logic      [7:0] prbs_o,
  // Switch reset handshake; delay picks a prompt or slow switch.
  input  wire logic       sw_reset_i,
  input  wire logic [3:0] delay_i,
  output logic            sw_done_o
);
  logic [3:0] wait_reg; // Cycles the reset command has been held.

  // Each byte encodes unit and offset, so a swapped byte shows up.
  assign cfg_byte_o = {unit_i[1:0], area_idx_i};
  // Settings differ per unit and per field.
  assign ais_o  = 8'h10 + unit_i;
  assign loop_o = 8'h20 + unit_i;
  assign prbs_o = 8'h30 + unit_i;

  // Done only after the held command has run for the programmed delay.
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      wait_reg <= 4'h0;
    else if (!sw_reset_i)
      wait_reg <= 4'h0;
    else if (!sw_done_o)
      wait_reg <= wait_reg + 4'h1;
  assign sw_done_o = sw_reset_i && (wait_reg >= delay_i);
endmodule // lirs_unit_model

/* sim/tb_lirs_handler.sv */
`timescale 1ns/10ps
`include "lirs_params.svh"
module tb_lirs_handler;
  logic clk_i = 1'b0, rst_n_i = 1'b0, req_valid_i = 1'b0, req_rsp_i = 1'b0;
  logic [15:0] req_type_i = 16'h0000, req_len_i = 16'h0000;
  logic [7:0] req_id_i = 8'h00, unit_o, cfg_byte_i, ais, lp, prbs, st;
  logic [5:0] area_idx_o;
  logic [3:0] dly = 4'h0;
  logic req_ready_o, sw_reset_o, sw_done_i, cfm_byte_valid_o, cfm_valid_o;
  logic [7:0] cfm_byte_o, cfm_id_o, cfm_status_o;
  logic [5:0] cfm_byte_off_o;
  logic [15:0] cfm_type_o, cfm_len_o;
  logic [7:0] bytes [0:63]; // Confirmation area as collected.
  logic got_cfm;
  int nb, cyc, cfm_cyc, done_cyc, failures, total_checks;

  always #2 clk_i = ~clk_i;

  lirs_handler lirs_handler_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_type_i(req_type_i),
    .req_id_i(req_id_i), .req_len_i(req_len_i), .req_rsp_i(req_rsp_i),
    .req_ready_o(req_ready_o), .unit_o(unit_o), .area_idx_o(area_idx_o),
    .cfg_byte_i(cfg_byte_i), .ctl_ais_i(ais), .ctl_loop_i(lp),
    .ctl_prbs_i(prbs), .sw_reset_o(sw_reset_o), .sw_done_i(sw_done_i),
    .cfm_byte_valid_o(cfm_byte_valid_o), .cfm_byte_o(cfm_byte_o),
    .cfm_byte_off_o(cfm_byte_off_o), .cfm_valid_o(cfm_valid_o),
    .cfm_type_o(cfm_type_o), .cfm_id_o(cfm_id_o), .cfm_len_o(cfm_len_o),
    .cfm_status_o(cfm_status_o));
  lirs_unit_model lirs_unit_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .unit_i(unit_o), .area_idx_i(area_idx_o), .cfg_byte_o(cfg_byte_i),
    .ais_o(ais), .loop_o(lp), .prbs_o(prbs), .sw_reset_i(sw_reset_o),
    .delay_i(dly), .sw_done_o(sw_done_i));

  // Collect bytes and confirmations; also cut a hang short.
  always @(posedge clk_i)
  begin
    cyc = cyc + 1;
    if (cfm_byte_valid_o === 1'b1)
    begin
      bytes[cfm_byte_off_o] = cfm_byte_o;
      nb = nb + 1;
    end
    if (cfm_valid_o === 1'b1)
    begin
      got_cfm = 1'b1;
      st = cfm_status_o;
      cfm_cyc = cyc;
    end
    if (sw_done_i === 1'b1 && sw_reset_o === 1'b1)
      done_cyc = cyc;
    if (cyc == 5000)
    begin
      failures = failures + 1;
      test_done();
    end
  end

  task automatic check(input string nm, input logic [15:0] got, exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One request, held until taken, then a bounded wait for confirmation.
  task automatic run(input logic [15:0] t, input logic [7:0] id,
                     input logic [15:0] len, input logic rsp);
    int n;
    nb = 0;
    got_cfm = 1'b0;
    done_cyc = -1;
    @(negedge clk_i);
    {req_valid_i, req_type_i, req_id_i, req_len_i, req_rsp_i} =
      {1'b1, t, id, len, rsp};
    while (req_ready_o !== 1'b1)
      @(negedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    for (n = 0; n < 100 && !got_cfm; n++)
      @(negedge clk_i);
  endtask

  task automatic t_cfg(input logic [7:0] id);
    run(`LIRS_TYPE_CFG_RB, id, `LIRS_LEN_CFG, 1'b1);
    check("cfg_status", {got_cfm, st}, 16'h0100);
    check("cfg_count", nb[15:0], 16'd40);
    check("cfg_echo", cfm_id_o, id);
    check("cfg_type", cfm_type_o, `LIRS_TYPE_CFG_RB);
    check("cfg_len", cfm_len_o, `LIRS_LEN_CFG);
    for (int i = 0; i < 40; i++)
      check("cfg_byte", bytes[i], {id[1:0], i[5:0]});
  endtask

  task automatic t_ctl(input logic [7:0] id);
    logic [7:0] e;
    run(`LIRS_TYPE_CTL_RB, id, `LIRS_LEN_CTL, 1'b1);
    check("ctl_status", {got_cfm, st}, 16'h0100);
    check("ctl_count", nb[15:0], 16'd16);
    check("ctl_type", cfm_type_o, `LIRS_TYPE_CTL_RB);
    check("ctl_len", cfm_len_o, `LIRS_LEN_CTL);
    for (int i = 0; i < 16; i++)
    begin
      e = (i == 0) ? 8'h10 + id : (i == 2) ? 8'h20 + id :
          (i == 4) ? 8'h30 + id : 8'h00;
      check("ctl_byte", bytes[i], e);
    end
  endtask

  // Confirmation comes two edges after the switch reports done.
  task automatic t_rst(input logic [3:0] d);
    dly = d;
    run(`LIRS_TYPE_SW_RST, 8'h00, `LIRS_LEN_RST, 1'b1);
    check("rst_status", {got_cfm, st}, 16'h0100);
    check("rst_type", cfm_type_o, `LIRS_TYPE_SW_RST);
    check("rst_order", 16'(cfm_cyc - done_cyc), 16'd2);
  endtask

  // Bad index, length, reset id and type, and missing confirmation.
  task automatic t_err();
    run(`LIRS_TYPE_CFG_RB, 8'h04, `LIRS_LEN_CFG, 1'b1);
    check("bad_id", {got_cfm, st != 8'h00, nb[7:0]}, 16'h0300);
    run(`LIRS_TYPE_CTL_RB, 8'h01, `LIRS_LEN_CFG, 1'b1);
    check("bad_len", {got_cfm, st != 8'h00, nb[7:0]}, 16'h0300);
    run(`LIRS_TYPE_SW_RST, 8'h01, `LIRS_LEN_RST, 1'b1);
    check("rst_bad_id", {got_cfm, done_cyc == -1}, 16'h0003);
    run(`LIRS_TYPE_SW_RST, 8'h00, `LIRS_LEN_RST, 1'b0);
    check("rst_quiet", {got_cfm, done_cyc > 0}, 16'h0001);
    run(16'h5e39, 8'h00, `LIRS_LEN_CTL, 1'b1);
    check("bad_type", {got_cfm, st}, 16'h0103);
    check("bad_type_bytes", nb[15:0], 16'h0000);
    run(`LIRS_TYPE_CFG_RB, 8'h01, `LIRS_LEN_CFG, 1'b0);
    check("cfg_quiet", {got_cfm, nb[7:0]}, 16'h0000);
  endtask

  task automatic test_done();
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_cfg(8'h03);
    t_cfg(8'h00);
    t_ctl(8'h02);
    t_rst(4'h0);
    t_rst(4'h9);
    t_err();
    t_ctl(8'h01);
    test_done();
  end
endmodule // tb_lirs_handler
